// ===== ofd_pkg.sv
package ofd_pkg;
   // Instruction classes presented by the fetch stage.
   typedef enum logic [3:0] {
      OFD_CLS_NONE, OFD_CLS_BYTE, OFD_CLS_BIT, OFD_CLS_MOVE,
      OFD_CLS_LIT8, OFD_CLS_LIT12, OFD_CLS_TABLE, OFD_CLS_REL8,
      OFD_CLS_REL11, OFD_CLS_ABS
   } ofd_class_t;

   // Table pointer update modes.
   typedef enum logic [1:0] {
      OFD_TBL_KEEP, OFD_TBL_POST_INC, OFD_TBL_POST_DEC, OFD_TBL_PRE_INC
   } ofd_tbl_mode_t;

   // Register byte offsets.
   localparam logic [11:0] OFD_BANK_OFS = 12'h000;
   localparam logic [11:0] OFD_TPTR_OFS = 12'h004;
   localparam logic [11:0] OFD_WORK_OFS = 12'h008;
   localparam logic [11:0] OFD_STATUS_OFS = 12'h00C;

   // Reset values.
   localparam logic [3:0] OFD_BANK_RST = 4'h0;
   localparam logic [20:0] OFD_TPTR_RST = 21'h000000;
   localparam logic [7:0] OFD_WORK_RST = 8'h00;

   // Operand field positions in the first instruction word.
   localparam int OFD_A_POS = 8;
   localparam int OFD_D_POS = 9;
   localparam int OFD_B_LSB = 9;
   localparam int OFD_M_LSB = 0;

   // Access area split: low file addresses map to bank 0, high to top bank.
   localparam logic [7:0] OFD_ACCESS_SPLIT = 8'h80;
   localparam logic [3:0] OFD_ACCESS_LO_BANK = 4'h0;
   localparam logic [3:0] OFD_ACCESS_HI_BANK = 4'hF;
endpackage

// ===== ofd_table_pointer_unit.sv
module ofd_ptr_unit
   import ofd_pkg::*;
(
   input wire logic [20:0] ptr,
   input wire ofd_tbl_mode_t mode,
   output logic [20:0] access_addr,
   output logic [20:0] next_ptr
);
   // Picks the address used by the transfer and the pointer left after it.
   always_comb begin
      access_addr = ptr;
      next_ptr = ptr;
      case (mode)
         OFD_TBL_KEEP: begin
            next_ptr = ptr; // [RQ9]
         end
         OFD_TBL_POST_INC: begin
            next_ptr = ptr + 21'h000001; // [RQ9]
         end
         OFD_TBL_POST_DEC: begin
            next_ptr = ptr - 21'h000001; // [RQ9]
         end
         default: begin
            access_addr = ptr + 21'h000001; // [RQ9]
            next_ptr = ptr + 21'h000001;
         end
      endcase
   end
endmodule

// ===== ofd_decoder.sv
// Functional notes
// RQ1: a=1 forms address from bank plus file.
// RQ2: a=0 addresses access area, bank ignored.
// RQ3: d=0 writes working register, d=1 file.
// RQ4: bit field selects bit 0 to 7.
// RQ5: file field is 8-bit address 00..FF.
// RQ6: moves use full 12-bit source and destination.
// RQ7: literals of 8, 12 or 20 bits.
// RQ8: table mode used only by table instructions.
// RQ9: four table pointer updates per mode field.
// RQ10: relative offsets signed, call/branch targets absolute.
// RQ11: relative target is next PC plus words.
module ofd_decoder
   import ofd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic instr_valid,
   input wire ofd_class_t instr_class,
   input wire logic [15:0] instr_word,
   input wire logic [15:0] instr_word2,
   input wire logic [20:0] pc_next,
   input wire logic result_valid,
   input wire logic [7:0] result_data,
   output logic dec_valid,
   output logic [11:0] ram_addr,
   output logic [11:0] move_src_addr,
   output logic [11:0] move_dst_addr,
   output logic [2:0] bit_sel,
   output logic [7:0] bit_mask,
   output logic [19:0] literal,
   output logic [20:0] branch_target,
   output logic tbl_strobe,
   output logic [20:0] tbl_addr,
   output logic file_wr_en,
   output logic [11:0] file_wr_addr,
   output logic [7:0] file_wr_data
);
   logic [3:0] bank_select_register_reg;
   logic [20:0] table_pointer_reg;
   logic [7:0] working_register_reg;
   logic dest_file_reg;
   logic dec_valid_reg;
   logic [11:0] ram_addr_reg, move_src_reg, move_dst_reg;
   logic [2:0] bit_sel_reg;
   logic [7:0] bit_mask_reg;
   logic [19:0] literal_reg;
   logic [20:0] branch_target_reg, tbl_addr_reg;
   logic tbl_strobe_reg, file_wr_en_reg;
   logic [11:0] file_wr_addr_reg;
   logic [7:0] file_wr_data_reg;
   logic [31:0] prdata_reg;
   logic [20:0] tbl_access, tbl_next;
   logic [20:0] rel_off;
   logic apb_wr, apb_setup, is_table, decode;
   ofd_tbl_mode_t tbl_mode;

   // Maps the access bit, file field and bank into a data RAM address.
   function automatic logic [11:0] ram_map(input logic a, input logic [7:0] f,
                                           input logic [3:0] bank);
      if (a) begin
         ram_map = {bank, f}; // [RQ1]
      end else if (f < OFD_ACCESS_SPLIT) begin
         ram_map = {OFD_ACCESS_LO_BANK, f}; // [RQ2]
      end else begin
         ram_map = {OFD_ACCESS_HI_BANK, f}; // [RQ2]
      end
   endfunction

   // Bus handshake and decode qualifiers; the bus stalls while ce is low.
   assign pready = ce;
   assign pslverr = !(paddr == OFD_BANK_OFS || paddr == OFD_TPTR_OFS ||
                      paddr == OFD_WORK_OFS || paddr == OFD_STATUS_OFS);
   assign apb_wr = psel && penable && pwrite && ce;
   assign apb_setup = psel && !penable && ce;
   assign decode = instr_valid && ce;
   assign is_table = instr_class == OFD_CLS_TABLE;
   assign tbl_mode = ofd_tbl_mode_t'(instr_word[OFD_M_LSB +: 2]);

   // Sign-extended relative offset chosen by branch length.
   always_comb begin
      if (instr_class == OFD_CLS_REL11) begin
         rel_off = {{10{instr_word[10]}}, instr_word[10:0]}; // [RQ10]
      end else begin
         rel_off = {{13{instr_word[7]}}, instr_word[7:0]}; // [RQ10]
      end
   end

   ofd_ptr_unit u_tbl (
      .ptr(table_pointer_reg),
      .mode(tbl_mode),
      .access_addr(tbl_access),
      .next_ptr(tbl_next)
   );

   // Bank select register, written by software.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank_select_register_reg <= OFD_BANK_RST;
      end else if (apb_wr && paddr == OFD_BANK_OFS) begin
         bank_select_register_reg <= pwdata[3:0];
      end
   end

   // Table pointer; a table instruction wins over a software write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         table_pointer_reg <= OFD_TPTR_RST;
      end else if (decode && is_table) begin
         table_pointer_reg <= tbl_next; // [RQ8] [RQ9]
      end else if (apb_wr && paddr == OFD_TPTR_OFS) begin
         table_pointer_reg <= pwdata[20:0];
      end
   end

   // Working register and file write-back of datapath results.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         working_register_reg <= OFD_WORK_RST;
         file_wr_en_reg <= 1'b0;
         file_wr_addr_reg <= 12'h000;
         file_wr_data_reg <= 8'h00;
      end else if (ce) begin
         file_wr_en_reg <= result_valid && dest_file_reg; // [RQ3]
         if (result_valid && !dest_file_reg) begin
            working_register_reg <= result_data; // [RQ3]
         end else if (apb_wr && paddr == OFD_WORK_OFS) begin
            working_register_reg <= pwdata[7:0];
         end
         if (result_valid && dest_file_reg) begin
            file_wr_addr_reg <= ram_addr_reg;
            file_wr_data_reg <= result_data;
         end
      end
   end

   // Operand field decode, registered for the execute stage.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dec_valid_reg <= 1'b0;
         dest_file_reg <= 1'b0;
         ram_addr_reg <= 12'h000;
         move_src_reg <= 12'h000;
         move_dst_reg <= 12'h000;
         bit_sel_reg <= 3'h0;
         bit_mask_reg <= 8'h00;
         literal_reg <= 20'h00000;
         branch_target_reg <= 21'h000000;
         tbl_strobe_reg <= 1'b0;
         tbl_addr_reg <= 21'h000000;
      end else if (ce) begin
         dec_valid_reg <= instr_valid;
         tbl_strobe_reg <= instr_valid && is_table; // [RQ8]
         if (instr_valid) begin
            case (instr_class)
               OFD_CLS_BYTE: begin
                  ram_addr_reg <= ram_map(instr_word[OFD_A_POS],
                     instr_word[7:0], bank_select_register_reg); // [RQ5]
                  dest_file_reg <= instr_word[OFD_D_POS]; // [RQ3]
               end
               OFD_CLS_BIT: begin
                  ram_addr_reg <= ram_map(instr_word[OFD_A_POS],
                     instr_word[7:0], bank_select_register_reg); // [RQ5]
                  bit_sel_reg <= instr_word[OFD_B_LSB +: 3]; // [RQ4]
                  bit_mask_reg <= 8'h01 << instr_word[OFD_B_LSB +: 3];
                  dest_file_reg <= 1'b1;
               end
               OFD_CLS_MOVE: begin
                  move_src_reg <= instr_word[11:0]; // [RQ6]
                  move_dst_reg <= instr_word2[11:0]; // [RQ6]
               end
               OFD_CLS_LIT8: begin
                  literal_reg <= {12'h000, instr_word[7:0]}; // [RQ7]
                  dest_file_reg <= 1'b0;
               end
               OFD_CLS_LIT12: begin
                  literal_reg <= {8'h00, instr_word[3:0],
                                  instr_word2[7:0]}; // [RQ7]
               end
               OFD_CLS_TABLE: begin
                  tbl_addr_reg <= tbl_access; // [RQ9]
               end
               OFD_CLS_REL8, OFD_CLS_REL11: begin
                  branch_target_reg <= pc_next +
                     {rel_off[19:0], 1'b0}; // [RQ11]
               end
               OFD_CLS_ABS: begin
                  literal_reg <= {instr_word2[11:0], instr_word[7:0]};
                  branch_target_reg <= {instr_word2[11:0], instr_word[7:0],
                                        1'b0}; // [RQ7] [RQ10]
               end
               default: begin
                  dest_file_reg <= dest_file_reg;
               end
            endcase
         end
      end
   end

   // Read data captured in the setup phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h00000000;
      end else if (apb_setup) begin
         if (paddr == OFD_BANK_OFS) begin
            prdata_reg <= {28'h0000000, bank_select_register_reg};
         end else if (paddr == OFD_TPTR_OFS) begin
            prdata_reg <= {11'h000, table_pointer_reg};
         end else if (paddr == OFD_WORK_OFS) begin
            prdata_reg <= {24'h000000, working_register_reg};
         end else if (paddr == OFD_STATUS_OFS) begin
            prdata_reg <= {15'h0000, dest_file_reg, dec_valid_reg,
                           3'h0, ram_addr_reg};
         end else begin
            prdata_reg <= 32'h00000000;
         end
      end
   end

   // Output drive.
   assign prdata = prdata_reg;
   assign dec_valid = dec_valid_reg;
   assign ram_addr = ram_addr_reg;
   assign move_src_addr = move_src_reg;
   assign move_dst_addr = move_dst_reg;
   assign bit_sel = bit_sel_reg;
   assign bit_mask = bit_mask_reg;
   assign literal = literal_reg;
   assign branch_target = branch_target_reg;
   assign tbl_strobe = tbl_strobe_reg;
   assign tbl_addr = tbl_addr_reg;
   assign file_wr_en = file_wr_en_reg;
   assign file_wr_addr = file_wr_addr_reg;
   assign file_wr_data = file_wr_data_reg;

   // Checks on the decoded operands.
   bank_ram_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ1]
      decode && instr_class == OFD_CLS_BYTE && instr_word[OFD_A_POS] |=>
      ram_addr == {$past(bank_select_register_reg), $past(instr_word[7:0])})
      else $error("banked address wrong");
   acc_area_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ2]
      decode && instr_class == OFD_CLS_BIT && !instr_word[OFD_A_POS] |=>
      ram_addr[11:8] == ($past(instr_word[7]) ? 4'hF : 4'h0))
      else $error("access area address wrong");
   dest_sel_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ3]
      ce && result_valid && !dest_file_reg |=>
      working_register_reg == $past(result_data) && !file_wr_en)
      else $error("result not sent to working register");
   bit_mask_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ4]
      decode && instr_class == OFD_CLS_BIT |=>
      bit_mask == (8'h01 << $past(instr_word[11:9])) && $onehot(bit_mask))
      else $error("bit mask wrong");
   file_fld_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ5]
      decode && instr_class == OFD_CLS_BYTE |=>
      ram_addr[7:0] == $past(instr_word[7:0]) && dec_valid)
      else $error("file field wrong");
   mov_addr_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ6]
      decode && instr_class == OFD_CLS_MOVE |=>
      move_src_addr == $past(instr_word[11:0]) &&
      move_dst_addr == $past(instr_word2[11:0]))
      else $error("move addresses wrong");
   lit12_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ7]
      decode && instr_class == OFD_CLS_LIT12 |=>
      literal == {8'h00, $past(instr_word[3:0]), $past(instr_word2[7:0])})
      else $error("12-bit literal wrong");
   tbl_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ8]
      decode && !is_table && !(apb_wr && paddr == OFD_TPTR_OFS) |=>
      $stable(table_pointer_reg) && !tbl_strobe)
      else $error("table pointer moved outside table op");
   tbl_pre_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ9]
      decode && is_table && tbl_mode == OFD_TBL_PRE_INC |=>
      tbl_addr == $past(table_pointer_reg) + 21'h000001 &&
      table_pointer_reg == tbl_addr)
      else $error("pre-increment wrong");
   rel_tgt_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ11]
      decode && instr_class == OFD_CLS_REL8 |=>
      branch_target == $past(pc_next) +
      {{12{$past(instr_word[7])}}, $past(instr_word[7:0]), 1'b0})
      else $error("relative target wrong");
endmodule

// ===== testbench.sv
module testbench import ofd_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, instr_valid = 1'b0;
   ofd_class_t instr_class = OFD_CLS_NONE;
   logic [15:0] instr_word = 16'h0, instr_word2 = 16'h0;
   logic [20:0] pc_next = 21'h0, branch_target, tbl_addr;
   logic result_valid = 1'b0, dec_valid, tbl_strobe, file_wr_en;
   logic [7:0] result_data = 8'h00, bit_mask, file_wr_data;
   logic [11:0] ram_addr, move_src_addr, move_dst_addr, file_wr_addr;
   logic [2:0] bit_sel;
   logic [19:0] literal;
   int mismatches = 0, total_checks = 0;
   logic [20:0] exp_tbl [4] = '{21'h100, 21'h100, 21'h101, 21'h101};

   // The clock toggles every 20 ns, a period of 40 ns.
   always #20 pclk = ~pclk;

   ofd_decoder DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .instr_valid(instr_valid), .instr_class(instr_class),
      .instr_word(instr_word), .instr_word2(instr_word2), .pc_next(pc_next),
      .result_valid(result_valid), .result_data(result_data),
      .dec_valid(dec_valid), .ram_addr(ram_addr),
      .move_src_addr(move_src_addr), .move_dst_addr(move_dst_addr),
      .bit_sel(bit_sel), .bit_mask(bit_mask), .literal(literal),
      .branch_target(branch_target), .tbl_strobe(tbl_strobe),
      .tbl_addr(tbl_addr), .file_wr_en(file_wr_en),
      .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data));

   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [31:0] got, exp, input string m);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // One APB transfer; the request is held until pready is seen high, for at most 20 cycles.
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d, output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk(1'b0, 1'b1, "apb wait");
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Presents one instruction for a single cycle and checks dec_valid.
   task automatic dec(input ofd_class_t c, input logic [15:0] w, w2);
      @(posedge pclk);
      instr_class <= c;
      instr_word <= w;
      instr_word2 <= w2;
      instr_valid <= 1'b1;
      @(posedge pclk);
      instr_valid <= 1'b0;
      @(negedge pclk);
      chk(dec_valid, 1, "dec_valid");
   endtask

   // Hands a datapath result in and waits one cycle for the write-back.
   task automatic res(input logic [7:0] d);
      @(posedge pclk);
      result_valid <= 1'b1;
      result_data <= d;
      @(posedge pclk);
      result_valid <= 1'b0;
      @(negedge pclk);
   endtask

   // Bank select, access area and register map including a bad address.
   task automatic t_bank();
      apb(1'b1, OFD_BANK_OFS, 32'h5, rd, er);
      apb(1'b0, OFD_BANK_OFS, 32'h0, rd, er);
      chk(rd, 32'h5, "bank readback");
      dec(OFD_CLS_BYTE, 16'h013C, 16'h0);
      chk(ram_addr, 12'h53C, "banked addr");
      dec(OFD_CLS_BYTE, 16'h003C, 16'h0);
      chk(ram_addr, 12'h03C, "access low");
      dec(OFD_CLS_BYTE, 16'h009A, 16'h0);
      chk(ram_addr, 12'hF9A, "access high");
      apb(1'b1, OFD_STATUS_OFS, 32'hFFFF_FFFF, rd, er);
      apb(1'b0, OFD_STATUS_OFS, 32'h0, rd, er);
      chk(rd, 32'h0000_0F9A, "status");
      apb(1'b0, 12'h010, 32'h0, rd, er);
      chk(er, 1, "unmapped err");
      chk(rd, 32'h0, "unmapped data");
      $display("bank test done");
   endtask

   // Destination select sends the result to the file or working register.
   task automatic t_dest();
      dec(OFD_CLS_BYTE, 16'h0205, 16'h0);
      res(8'h77);
      chk(file_wr_en, 1, "file write");
      chk(file_wr_addr, 12'h005, "file addr");
      chk(file_wr_data, 8'h77, "file data");
      dec(OFD_CLS_BYTE, 16'h0006, 16'h0);
      res(8'h3C);
      chk(file_wr_en, 0, "no file write");
      apb(1'b0, OFD_WORK_OFS, 32'h0, rd, er);
      chk(rd, 32'h3C, "working reg");
      $display("dest test done");
   endtask

   // Every bit position, plus both ends of the file address range.
   task automatic t_bit();
      for (int b = 0; b < 8; b++) begin
         dec(OFD_CLS_BIT, {4'h0, b[2:0], 1'b0, 8'hFF}, 16'h0);
         chk(bit_sel, b[2:0], "bit sel");
         chk(bit_mask, 8'h01 << b, "bit mask");
         chk(ram_addr, 12'hFFF, "file FF");
      end
      dec(OFD_CLS_BIT, 16'h0100, 16'h0);
      chk(ram_addr, 12'h500, "file 00");
      $display("bit test done");
   endtask

   // Moves, literals of each width and absolute and relative targets.
   task automatic t_ops();
      dec(OFD_CLS_MOVE, 16'hCABC, 16'hF123);
      chk(move_src_addr, 12'hABC, "move src");
      chk(move_dst_addr, 12'h123, "move dst");
      dec(OFD_CLS_LIT8, 16'h0EA5, 16'h0);
      chk(literal, 20'h000A5, "lit8");
      dec(OFD_CLS_LIT12, 16'h0007, 16'hF0C4);
      chk(literal, 20'h007C4, "lit12");
      dec(OFD_CLS_ABS, 16'h00E1, 16'hFABC);
      chk(literal, 20'hABCE1, "lit20");
      chk(branch_target, 21'h1579C2, "abs target");
      @(posedge pclk);
      pc_next <= 21'h000100;
      dec(OFD_CLS_REL8, 16'h00FF, 16'h0);
      chk(branch_target, 21'h0000FE, "rel back");
      dec(OFD_CLS_REL8, 16'h007F, 16'h0);
      chk(branch_target, 21'h0001FE, "rel fwd");
      @(posedge pclk);
      pc_next <= 21'h000010;
      dec(OFD_CLS_REL11, 16'h0400, 16'h0);
      chk(branch_target, 21'h1FF810, "rel11 wrap");
      $display("operand test done");
   endtask

   // All four pointer modes, then a mode field on a non-table class.
   task automatic t_table();
      apb(1'b1, OFD_TPTR_OFS, 32'h100, rd, er);
      for (int m = 0; m < 4; m++) begin
         dec(OFD_CLS_TABLE, {14'h0, m[1:0]}, 16'h0);
         chk(tbl_strobe, 1, "tbl strobe");
         chk(tbl_addr, exp_tbl[m], "tbl addr");
      end
      apb(1'b0, OFD_TPTR_OFS, 32'h0, rd, er);
      chk(rd, 32'h101, "tbl ptr");
      dec(OFD_CLS_BYTE, 16'h0003, 16'h0);
      chk(tbl_strobe, 0, "no strobe");
      apb(1'b0, OFD_TPTR_OFS, 32'h0, rd, er);
      chk(rd, 32'h101, "ptr kept");
      $display("table test done");
   endtask

   // Enable low freezes decode and stalls the bus; an empty class keeps fields.
   task automatic t_ce();
      @(posedge pclk);
      ce <= 1'b0;
      instr_class <= OFD_CLS_BYTE;
      instr_word <= 16'h0111;
      instr_valid <= 1'b1;
      @(posedge pclk);
      instr_valid <= 1'b0;
      @(negedge pclk);
      chk(dec_valid, 0, "frozen valid");
      chk(ram_addr, 12'h003, "frozen addr");
      chk(pready, 0, "bus stalled");
      @(posedge pclk);
      ce <= 1'b1;
      dec(OFD_CLS_NONE, 16'h0111, 16'h0);
      chk(ram_addr, 12'h003, "none keeps addr");
      $display("enable test done");
   endtask

   // Reset for four cycles, then the tests in turn.
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_bank();
      t_dest();
      t_bit();
      t_ops();
      t_table();
      t_ce();
      wrap_up();
   end

   // Cuts a hang short well after the tests should have ended.
   initial begin
      #(40 * 3000);
      mismatches++;
      wrap_up();
   end
endmodule
